// ---- tsq_pkg.sv ----
// Package for the 8-bit square-wave timer: register map, fields, constants
package tsq_pkg;
    // Register byte offsets
    localparam logic [7:0] TSQ_MODE_OFS    = 8'h00;
    localparam logic [7:0] TSQ_CMP_OFS     = 8'h04;
    localparam logic [7:0] TSQ_CLKSEL_OFS  = 8'h08;
    localparam logic [7:0] TSQ_COUNT_OFS   = 8'h0c;
    localparam logic [7:0] TSQ_STATUS_OFS  = 8'h10;
    localparam logic [7:0] TSQ_MASK_OFS    = 8'h14;

    // Mode control bit positions
    localparam int TSQ_OUT_EN_BIT  = 0;
    localparam int TSQ_LVL_SET_BIT = 3;
    localparam int TSQ_LVL_CLR_BIT = 2;
    localparam int TSQ_CNT_EN_BIT  = 7;

    // Reset values
    localparam logic [7:0] TSQ_MODE_RST   = 8'h00;
    localparam logic [7:0] TSQ_CMP_RST    = 8'h00;
    localparam logic [2:0] TSQ_CLKSEL_RST = 3'h0;
    localparam logic [7:0] TSQ_COUNT_CLR  = 8'h00;

    // Prescaler width; selection n divides hclk by 2**n
    localparam int TSQ_PRE_W = 8;

    // Decoded mode control fields
    typedef struct packed {
        logic count_enable_bit;
        logic level_set_bit;
        logic level_reset_bit;
        logic output_enable_bit;
    } tsq_mode_type;

    // Latched AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } tsq_aphase_type;
endpackage

// ---- tsq_timer.sv ----
// 8-bit timer in square-wave output mode with an AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module tsq_timer
    import tsq_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             square_wave_output_pin,
    output logic             irq
);

    logic [7:0]           timer_mode_ctrl;
    logic [7:0]           compare_value_reg;
    logic [2:0]           count_clock_select;
    logic [7:0]           counter_value;
    logic                 match_status;
    logic                 match_mask;
    logic [TSQ_PRE_W-1:0] prescale;
    logic [TSQ_PRE_W-1:0] prescale_prev;
    logic                 tick;
    logic                 match;
    logic                 match_interrupt;
    logic                 outff;
    tsq_aphase_type       aph;
    tsq_mode_type         mode;
    logic                 wr_en;

    ////////////////////////////////////////////////////////////////////////
    // Field decode of the mode register
    assign mode.count_enable_bit  = timer_mode_ctrl[TSQ_CNT_EN_BIT];
    assign mode.level_set_bit     = timer_mode_ctrl[TSQ_LVL_SET_BIT];
    assign mode.level_reset_bit   = timer_mode_ctrl[TSQ_LVL_CLR_BIT];
    assign mode.output_enable_bit = timer_mode_ctrl[TSQ_OUT_EN_BIT];

    // Address decode, used by the write path and the status clear; the read mux decodes haddr itself
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AHB address phase capture; slave is always zero-wait, OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph <= '0;
        end else if (hready) begin
            aph.valid <= hsel && htrans[1];
            aph.write <= hwrite;
            aph.addr  <= haddr[7:0];
        end
    end

    assign wr_en = aph.valid && aph.write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Configuration writes; compare and clock held while running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_mode_ctrl    <= TSQ_MODE_RST;
            compare_value_reg  <= TSQ_CMP_RST;
            count_clock_select <= TSQ_CLKSEL_RST;
            match_mask         <= 1'b0;
        end else if (wr_en) begin
            if (hit(aph.addr, TSQ_MODE_OFS))
                timer_mode_ctrl <= hwdata[7:0];
            // Ignoring edits while running keeps the interval stable
            if (hit(aph.addr, TSQ_CMP_OFS) && !mode.count_enable_bit)
                compare_value_reg <= hwdata[7:0];
            if (hit(aph.addr, TSQ_CLKSEL_OFS) && !mode.count_enable_bit)
                count_clock_select <= hwdata[2:0];
            if (hit(aph.addr, TSQ_MASK_OFS))
                match_mask <= hwdata[0];
        end
    end

    // Read mux; unmapped offsets read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                TSQ_MODE_OFS:   hrdata <= {24'h0, timer_mode_ctrl};
                TSQ_CMP_OFS:    hrdata <= {24'h0, compare_value_reg};
                TSQ_CLKSEL_OFS: hrdata <= {29'h0, count_clock_select};
                TSQ_COUNT_OFS:  hrdata <= {24'h0, counter_value};
                TSQ_STATUS_OFS: hrdata <= {31'h0, match_status};
                TSQ_MASK_OFS:   hrdata <= {31'h0, match_mask};
                default:        hrdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running prescaler; tick on rising edge of the selected tap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale      <= '0;
            prescale_prev <= '0;
        end else begin
            prescale      <= prescale + 1'b1;
            prescale_prev <= prescale;
        end
    end

    // Selection 0 ticks every hclk; n ticks every 2**n cycles
    assign tick = (count_clock_select == 3'h0) ? 1'b1 :
        (prescale[count_clock_select - 3'h1] &&
         !prescale_prev[count_clock_select - 3'h1]);

    assign match = mode.count_enable_bit && tick &&
                   (counter_value == compare_value_reg);
    assign match_interrupt = match;

    // Counter: N+1 ticks per half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_value <= TSQ_COUNT_CLR;
        end else if (!mode.count_enable_bit) begin
            counter_value <= TSQ_COUNT_CLR;
        end else if (match) begin
            counter_value <= TSQ_COUNT_CLR;
        end else if (tick) begin
            counter_value <= counter_value + 8'h01;
        end
    end

    // Output flip-flop: preset while stopped, toggle on match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            outff <= 1'b0;
        end else begin
            if (!mode.count_enable_bit) begin
                if (mode.level_set_bit && !mode.level_reset_bit)
                    outff <= 1'b1;
                else if (mode.level_reset_bit && !mode.level_set_bit)
                    outff <= 1'b0;
            end else if (match) begin
                outff <= !outff;
            end
        end
    end

    // Pin follows the flip-flop only when output is enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            square_wave_output_pin <= 1'b0;
        end else begin
            square_wave_output_pin <= mode.output_enable_bit ? outff : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new match wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_status <= 1'b0;
        end else if (match_interrupt) begin
            match_status <= 1'b1;
        end else if (wr_en && hit(aph.addr, TSQ_STATUS_OFS) &&
                     hwdata[0]) begin
            match_status <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (match_status || match_interrupt) && match_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_match;
        match;
    endsequence

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        s_match |=> (outff != $past(outff));
    endproperty
    toggle_on_match_a: assert property (p_toggle)
        else $error("output did not toggle on match");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        s_match |=> (counter_value == 8'h00);
    endproperty
    match_clears_a: assert property (p_clear)
        else $error("counter not cleared after match");

    stopped_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode.count_enable_bit |=> counter_value == 8'h00)
        else $error("counter moved while stopped");

    count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode.count_enable_bit && tick && !match &&
         $past(mode.count_enable_bit))
        |=> counter_value == $past(counter_value) + 8'h01)
        else $error("counter did not step by one");

    no_tick_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode.count_enable_bit && !tick) ##1 mode.count_enable_bit
        |-> counter_value == $past(counter_value))
        else $error("counter moved without a tick");

    preset_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mode.count_enable_bit && mode.level_reset_bit &&
         !mode.level_set_bit) |=> !outff)
        else $error("preset low failed");

    preset_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mode.count_enable_bit && mode.level_set_bit &&
         !mode.level_reset_bit) |=> outff)
        else $error("preset high failed");

    status_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_match |=> match_status ##1 (irq || !$past(match_mask)))
        else $error("match status or interrupt missing");

endmodule // tsq_timer

// ---- timer8_square_wave_output_tb.sv ----
// Self-checking testbench for the 8-bit square-wave timer
`timescale 1ns/1ns
module timer8_square_wave_output_tb import tsq_pkg::*;;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic        irq;
    logic [31:0] rd;
    int          failures = 0;
    int          tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    // Single slave, so its ready is the bus ready; pin watched with no latch
    tsq_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .square_wave_output_pin(pin), .irq(irq));

    // 50 MHz clock
    always #10 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////
    // Case-equality compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Cycles between two pin edges; bounded so a stuck pin cannot hang
    task automatic half(input int exp);
        int n;
        logic p;
        n = 0;
        p = pin;
        while (pin === p && n < 600) begin
            @(posedge hclk);
            n++;
        end
        p = pin;
        n = 0;
        while (pin === p && n < 600) begin
            @(posedge hclk);
            n++;
        end
        chk(n, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values, plus an unmapped place that must read zero
    task automatic t_reset;
        for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'h0);
        chk({30'h0, pin, irq}, 32'h0);
        bus(1'b1, 8'h20, 32'hffffffff);
        rdchk(8'h20, 32'h0);
        $display("test reset done");
    endtask

    // Preset levels while stopped; no counting without enable
    task automatic t_preset;
        // Preset lands one edge after the write, the pin one edge later
        bus(1'b1, TSQ_MODE_OFS, 32'h0b);
        cyc(3);
        chk({31'h0, pin}, 32'h1);
        bus(1'b1, TSQ_MODE_OFS, 32'h07);
        cyc(3);
        chk({31'h0, pin}, 32'h0);
        bus(1'b1, TSQ_MODE_OFS, 32'h0a);
        cyc(3);
        chk({31'h0, pin}, 32'h0);
        bus(1'b1, TSQ_MODE_OFS, 32'h0b);
        cyc(3);
        chk({31'h0, pin}, 32'h1);
        bus(1'b1, TSQ_CMP_OFS, 32'h02);
        cyc(20);
        rdchk(TSQ_COUNT_OFS, 32'h0);
        chk({31'h0, pin}, 32'h1);
        $display("test preset done");
    endtask

    // Half period is (N+1) ticks, tick every 2**sel cycles; two halves
    task automatic t_wave;
        logic [7:0] cmp [4] = '{8'h00, 8'h03, 8'hff, 8'h05};
        logic [2:0] sel [4] = '{3'h0, 3'h1, 3'h0, 3'h2};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, TSQ_MODE_OFS, 32'h0b);
            bus(1'b1, TSQ_CMP_OFS, {24'h0, cmp[i]});
            bus(1'b1, TSQ_CLKSEL_OFS, {29'h0, sel[i]});
            bus(1'b1, TSQ_MODE_OFS, 32'h8b);
            half((int'(cmp[i]) + 1) << sel[i]);
            half((int'(cmp[i]) + 1) << sel[i]);
        end
        $display("test wave done");
    endtask

    // Match status, mask, W1C clear; compare locked while running
    task automatic t_irq;
        bus(1'b1, TSQ_MODE_OFS, 32'h0b);
        bus(1'b1, TSQ_STATUS_OFS, 32'h1);
        bus(1'b1, TSQ_MASK_OFS, 32'h0);
        bus(1'b1, TSQ_CMP_OFS, 32'h03);
        bus(1'b1, TSQ_CLKSEL_OFS, 32'h0);
        rdchk(TSQ_STATUS_OFS, 32'h0);
        bus(1'b1, TSQ_MODE_OFS, 32'h8b);
        cyc(12);
        rdchk(TSQ_STATUS_OFS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, TSQ_MASK_OFS, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, TSQ_CMP_OFS, 32'h55);
        rdchk(TSQ_CMP_OFS, 32'h03);
        bus(1'b1, TSQ_MODE_OFS, 32'h0b);
        bus(1'b1, TSQ_STATUS_OFS, 32'h1);
        cyc(2);
        rdchk(TSQ_STATUS_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Reset for four cycles, then the scenarios in order
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_preset;
        t_wave;
        t_irq;
        summarize;
    end

    // Whole run is under 1500 cycles, against a limit of 50000 cycles; this is ample margin
    initial begin
        #1000000;
        failures++;
        summarize;
    end
endmodule // timer8_square_wave_output_tb
